// ---- bench/alias_tags_properties.sv ----
`default_nettype none
module alias_tags_properties (
   input wire logic clk,
   input wire logic srst,
   input wire logic ce,
   input wire logic op_valid,
   input wire alias_tags_pkg::op_t op_code,
   input wire logic op_fp_use,
   input wire logic [2:0] op_index,
   input wire logic [127:0] op_data,
   input wire logic [31:0] op_addr,
   input wire logic [2:0] rd_index,
   input wire logic [79:0] fp_rd_data,
   input wire logic [7:0] tag_valid,
   input wire logic stack_overflow,
   input wire logic align_fault,
   input wire logic line_split
);
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   // decoded op kinds; only taken ops count
   wire logic go = op_valid && ce;
   wire logic nar = op_code == alias_tags_pkg::OP_NARROW_WRITE ||
      op_code == alias_tags_pkg::OP_NARROW_REF;
   wire logic ovf = go && op_fp_use && tag_valid == 8'hff && !nar;
   wire logic bad = go && op_code == alias_tags_pkg::OP_WIDE_MEM &&
      op_addr[3:0] != 4'h0;
   wire logic spl = op_addr[2:0] != 3'h0 && op_addr[5:0] > 6'h38;
   wire logic [63:0] low = op_data[63:0];
   tags_set_a: assert property (
      go && op_code == alias_tags_pkg::OP_NARROW_REF |=> tag_valid == 8'hff)
      else $error("tags not set");
   tags_clear_a: assert property (
      go && op_code == alias_tags_pkg::OP_EMPTY |=> tag_valid == 8'h00)
      else $error("tags not cleared");
   overflow_flag_a: assert property (
      ce |=> stack_overflow == $past(ovf)) else $error("overflow flag");
   align_fault_a: assert property (
      ce |=> align_fault == $past(bad)) else $error("align flag");
   narrow_split_a: assert property (
      go && nar |=> !align_fault && line_split == $past(spl))
      else $error("narrow split");
   wide_tags_a: assert property (
      go && op_code >= alias_tags_pkg::OP_WIDE_WRITE && !op_fp_use
      |=> $stable(tag_valid)) else $error("wide op moved tags");
   shared_view_a: assert property (
      go && op_code == alias_tags_pkg::OP_NARROW_WRITE ##1 ce && !op_valid
      && rd_index == $past(op_index)
      |=> fp_rd_data == {16'hffff, $past(low, 2)})
      else $error("shared view");
   freeze_hold_a: assert property (
      !ce |=> $stable(tag_valid) && $stable(stack_overflow))
      else $error("state moved while frozen");
endmodule : alias_tags_properties
bind simd_fp_register_alias_tags alias_tags_properties chk_u (.*);
`default_nettype wire

// ---- bench/simd_fp_register_alias_tags_tb.sv ----
`default_nettype none
module simd_fp_register_alias_tags_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'h0, srst = 1'h1, ce = 1'h1, op_valid = 1'h0, op_fp_use = 1'h0;
   alias_tags_pkg::op_t op_code = alias_tags_pkg::OP_NONE, c;
   logic [2:0] op_index = 3'h0, rd_index = 3'h0;
   logic [127:0] op_data = 128'h0, wide_rd_data;
   logic [31:0] op_addr = 32'h0;
   logic [79:0] fp_rd_data;
   logic [63:0] narrow_rd_data, d;
   logic [7:0] tag_valid;
   logic stack_overflow, align_fault, line_split;
   int miscompares = 0, samples_checked = 0;
   simd_fp_register_alias_tags dut_u (
      .clk(clk),
      .srst(srst),
      .ce(ce),
      .op_valid(op_valid),
      .op_code(op_code),
      .op_fp_use(op_fp_use),
      .op_index(op_index),
      .op_data(op_data),
      .op_addr(op_addr),
      .rd_index(rd_index),
      .fp_rd_data(fp_rd_data),
      .narrow_rd_data(narrow_rd_data),
      .wide_rd_data(wide_rd_data),
      .tag_valid(tag_valid),
      .stack_overflow(stack_overflow),
      .align_fault(align_fault),
      .line_split(line_split)
   );
   initial forever #4 clk = ~clk;
   task automatic check(string what, logic [127:0] seen, exp);
      samples_checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   // one op for one edge, then idle so pulses are caught at the next negedge
   task automatic op(alias_tags_pkg::op_t k, logic f);
      {op_valid, op_code, op_fp_use} = {1'h1, k, f};
      @(negedge clk);
      op_valid = 1'h0;
   endtask : op
   function automatic logic fault_exp(alias_tags_pkg::op_t k, logic [3:0] a);
      return k == alias_tags_pkg::OP_WIDE_MEM && a != 4'h0;
   endfunction : fault_exp
   task automatic finish_test();
      $display("checked %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : finish_test
   // watchdog: the run needs under 1000 cycles
   initial begin
      #20000;
      miscompares++;
      finish_test();
   end
   initial begin
      void'($urandom(83));
      repeat (16) @(negedge clk);
      srst = 1'h0;
      check("reset tags", tag_valid, alias_tags_pkg::TAGS_RESET);
      op(alias_tags_pkg::OP_NARROW_REF, 1'h0);
      check("tags", tag_valid, 8'hff);
      op(alias_tags_pkg::OP_WIDE_WRITE, 1'h0);
      check("tags", tag_valid, 8'hff);
      op(alias_tags_pkg::OP_FP_WRITE, 1'h1);
      check("overflow", stack_overflow, 1'h1);
      op(alias_tags_pkg::OP_EMPTY, 1'h0);
      check("tags", tag_valid, 8'h00);
      op(alias_tags_pkg::OP_FP_WRITE, 1'h1);
      check("overflow", stack_overflow, 1'h0);
      $display("tag test done");
      for (int i = 0; i < 8; i++) begin
         {op_index, rd_index} = {3'(i), 3'(i)};
         op_data = {$urandom, $urandom, $urandom, $urandom};
         d = op_data[63:0];
         op(alias_tags_pkg::OP_NARROW_WRITE, 1'h0);
         @(negedge clk);
         check("fp view", fp_rd_data, {16'hffff, d});
         op_data = ~op_data;
         op(alias_tags_pkg::OP_WIDE_WRITE, 1'h0);
         @(negedge clk);
         check("wide", wide_rd_data, op_data);
         check("narrow kept", narrow_rd_data, d);
      end
      $display("alias test done");
      // low nibble sweep; line offsets 0x30-0x3f straddle the split point
      for (int k = 0; k < 32; k++) begin
         op_addr = {$urandom} & 32'hffffffc0 | 32'h30 | 32'(k % 16);
         c = k < 16 ? alias_tags_pkg::OP_WIDE_MEM :
            alias_tags_pkg::OP_WIDE_MEM_UNALIGNED;
         op(c, 1'h0);
         check("align", align_fault,
            fault_exp(c, op_addr[3:0]));
         op(alias_tags_pkg::OP_NARROW_REF, 1'h0);
         check("split", {align_fault, line_split},
            op_addr[3:0] > 4'h8);
      end
      $display("align test done");
      repeat (300) begin
         {op_valid, op_fp_use, op_index, rd_index, op_addr} = 40'({$urandom,
            $urandom});
         op_code = alias_tags_pkg::op_t'(3'($urandom));
         ce = $urandom_range(3) != 0;
         op_data = {$urandom, $urandom, $urandom, $urandom};
         @(negedge clk);
      end
      $display("random test done");
      finish_test();
   end
endmodule : simd_fp_register_alias_tags_tb
`default_nettype wire

// ---- shared/alias_tags_pkg.sv ----
// What this block does
// - narrow simd registers share floating stack storage
// - narrow simd reference sets all tag valid bits
// - empty-state instruction clears all tag valid bits
// - float op with all tags set raises overflow
// - narrow simd ops use the shared state
// - wide set is separate, tags untouched
// - unaligned wide reference raises alignment exception
// - unaligned wide move is exempt from alignment
// - unaligned narrow reference completes, maybe slower
// - type-mismatched wide data still gives same result
`default_nettype none
package alias_tags_pkg;
   localparam int NUM_REGS = 8;
   localparam int IDX_W = 3;
   localparam int NARROW_W = 64;
   localparam int FP_W = 80;
   localparam int WIDE_W = 128;
   localparam int ADDR_W = 32;
   localparam logic [7:0] TAGS_RESET = 8'h00;
   localparam logic [3:0] WIDE_ALIGN_MASK = 4'hf;
   localparam logic [2:0] NARROW_ALIGN_MASK = 3'h7;
   localparam logic [5:0] LINE_OFS_MASK = 6'h3f;
   localparam logic [5:0] NARROW_LAST_OFS = 6'h38;
   localparam logic [15:0] NARROW_EXP_ONES = 16'hffff;
   typedef enum logic [2:0] {
      OP_NONE, OP_FP_WRITE, OP_NARROW_WRITE, OP_NARROW_REF, OP_EMPTY,
      OP_WIDE_WRITE, OP_WIDE_MEM, OP_WIDE_MEM_UNALIGNED
   } op_t;
endpackage : alias_tags_pkg
`default_nettype wire

// ---- verilog/simd_fp_register_alias_tags.sv ----
`default_nettype none
module simd_fp_register_alias_tags (
   input wire logic clk,
   input wire logic srst,
   input wire logic ce,
   input wire logic op_valid,
   input wire alias_tags_pkg::op_t op_code,
   input wire logic op_fp_use,
   input wire logic [alias_tags_pkg::IDX_W-1:0] op_index,
   input wire logic [alias_tags_pkg::WIDE_W-1:0] op_data,
   input wire logic [alias_tags_pkg::ADDR_W-1:0] op_addr,
   input wire logic [alias_tags_pkg::IDX_W-1:0] rd_index,
   output logic [alias_tags_pkg::FP_W-1:0] fp_rd_data,
   output logic [alias_tags_pkg::NARROW_W-1:0] narrow_rd_data,
   output logic [alias_tags_pkg::WIDE_W-1:0] wide_rd_data,
   output logic [alias_tags_pkg::NUM_REGS-1:0] tag_valid,
   output logic stack_overflow,
   output logic align_fault,
   output logic line_split
);
   // shared 80-bit storage; the narrow view is the low 64 bits
   logic [alias_tags_pkg::FP_W-1:0] fp_reg [alias_tags_pkg::NUM_REGS];
   logic [alias_tags_pkg::FP_W-1:0] fp_next [alias_tags_pkg::NUM_REGS];
   logic [alias_tags_pkg::WIDE_W-1:0] wide_reg [alias_tags_pkg::NUM_REGS];
   logic [alias_tags_pkg::WIDE_W-1:0] wide_next [alias_tags_pkg::NUM_REGS];
   logic [alias_tags_pkg::NUM_REGS-1:0] tag_reg, tag_next;
   logic ovf_reg, ovf_next, align_reg, align_next, split_reg, split_next;
   logic [alias_tags_pkg::FP_W-1:0] fp_rd_reg, fp_rd_next;
   logic [alias_tags_pkg::NARROW_W-1:0] nar_rd_reg, nar_rd_next;
   logic [alias_tags_pkg::WIDE_W-1:0] wide_rd_reg, wide_rd_next;
   logic go, narrow_op, wide_mem_bad;

   assign go = ce & op_valid;
   assign narrow_op = (op_code == alias_tags_pkg::OP_NARROW_WRITE) ||
                      (op_code == alias_tags_pkg::OP_NARROW_REF);
   // only the aligning form of a wide memory reference checks the address
   assign wide_mem_bad = (op_code == alias_tags_pkg::OP_WIDE_MEM) &&
      ((op_addr[3:0] & alias_tags_pkg::WIDE_ALIGN_MASK) != 4'h0);

   // per entry, float and narrow views write the same 80-bit flops; the wide view has its own register
   for (genvar i = 0; i < alias_tags_pkg::NUM_REGS; i++) begin : g_ent
      always_comb begin
         fp_next[i] = fp_reg[i];
         wide_next[i] = wide_reg[i];
         if (go && int'(op_index) == i) begin
            case (op_code)
               alias_tags_pkg::OP_FP_WRITE: begin
                  fp_next[i] = op_data[alias_tags_pkg::FP_W-1:0];
               end
               alias_tags_pkg::OP_NARROW_WRITE: begin
                  // exponent forced to ones, as the float view then sees it
                  fp_next[i] = {alias_tags_pkg::NARROW_EXP_ONES,
                     op_data[alias_tags_pkg::NARROW_W-1:0]};
               end
               alias_tags_pkg::OP_WIDE_WRITE,
               alias_tags_pkg::OP_WIDE_MEM_UNALIGNED: begin
                  // raw bits kept whatever the type, so mixed use is exact
                  wide_next[i] = op_data;
               end
               alias_tags_pkg::OP_WIDE_MEM: begin
                  if (!wide_mem_bad) begin
                     wide_next[i] = op_data;
                  end
               end
               default: begin
               end
            endcase
         end
      end
      always_ff @(posedge clk) begin
         if (srst) begin
            fp_reg[i] <= '0;
            wide_reg[i] <= '0;
         end else if (ce) begin
            fp_reg[i] <= fp_next[i];
            wide_reg[i] <= wide_next[i];
         end
      end
   end

   // tag word and event flags; flags are one-cycle pulses per operation
   always_comb begin
      tag_next = tag_reg;
      ovf_next = 1'b0;
      align_next = 1'b0;
      split_next = 1'b0;
      if (go) begin
         // overflow judged on the tags before this op updates them
         if (op_fp_use && !narrow_op && tag_reg == '1) begin
            ovf_next = 1'b1;
         end
         if (narrow_op) begin
            tag_next = '1;
            // unaligned narrow access is never faulted, only flagged slow when it crosses the line end
            split_next = (op_addr[2:0] & alias_tags_pkg::NARROW_ALIGN_MASK)
               != 3'h0 && (op_addr[5:0] & alias_tags_pkg::LINE_OFS_MASK)
               > alias_tags_pkg::NARROW_LAST_OFS;
         end else if (op_code == alias_tags_pkg::OP_EMPTY) begin
            tag_next = '0;
         end
         // wide ops leave the tag word alone
         align_next = wide_mem_bad;
      end
   end

   // registered read port; narrow view reads the shared storage
   always_comb begin
      fp_rd_next = fp_reg[rd_index];
      nar_rd_next = fp_reg[rd_index][alias_tags_pkg::NARROW_W-1:0];
      wide_rd_next = wide_reg[rd_index];
   end

   // tag word on its own, so reset and freeze of the stack state are plain
   always_ff @(posedge clk) begin
      if (srst) begin
         tag_reg <= alias_tags_pkg::TAGS_RESET;
      end else if (ce) begin
         tag_reg <= tag_next;
      end
   end

   // event pulses; held, not dropped, while ce is low
   always_ff @(posedge clk) begin
      if (srst) begin
         ovf_reg <= 1'b0;
         align_reg <= 1'b0;
         split_reg <= 1'b0;
      end else if (ce) begin
         ovf_reg <= ovf_next;
         align_reg <= align_next;
         split_reg <= split_next;
      end
   end

   // read port registers; one cycle of latency buys a flop-driven output
   always_ff @(posedge clk) begin
      if (srst) begin
         fp_rd_reg <= '0;
         nar_rd_reg <= '0;
         wide_rd_reg <= '0;
      end else if (ce) begin
         fp_rd_reg <= fp_rd_next;
         nar_rd_reg <= nar_rd_next;
         wide_rd_reg <= wide_rd_next;
      end
   end

   assign tag_valid = tag_reg;
   assign stack_overflow = ovf_reg;
   assign align_fault = align_reg;
   assign line_split = split_reg;
   assign fp_rd_data = fp_rd_reg;
   assign narrow_rd_data = nar_rd_reg;
   assign wide_rd_data = wide_rd_reg;
endmodule : simd_fp_register_alias_tags
`default_nettype wire
